/* hdl/rcs_run_ctrl.sv */
// How it works
// RQ1: Step zero uses the ordinary frequency command
// RQ2: Seven stored step frequencies, zero to 400 Hz
// RQ3: Function codes 5,6,7 form step index bits
// RQ4: Keypad run key starts, stop key stops
// RQ5: Keypad run direction follows direction select
// RQ6: Remote keypad present disables built-in keys
// RQ7: Function codes 0 and 1 are forward/reverse
// RQ8: Mode 1: forward or reverse input runs
// RQ9: Mode 1: both or neither input stops
// RQ10: Mode 2: forward runs, reverse selects direction
// RQ11: Mode 3: serial link gives run commands
// RQ12: Negative bipolar input inverts commanded direction
// RQ13: Direction change decelerates to stop first
// RQ14: Inhibit setting blocks forward or reverse running
// RQ15: Power-on start runs with active terminal input
// RQ16: Fault restart runs if terminal still active
// RQ17: Power-on and fault restart only terminal modes
// RQ18: Source 2 takes reference from bipolar input
// RQ19: Disabled restart needs terminal cycled inactive first
// RQ20: Step frequency applied only while running
//
// Local design decisions: the register offsets and register access over Avalon-MM.
`timescale 1ns/100ps
module rcs_run_ctrl import rcs_pkg::*; #(
    parameter logic [31:0] CTRL_INIT = CTRL_RESET,
    parameter int ANALOG_W = 12
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic mf_input_one,
    input wire logic mf_input_two,
    input wire logic mf_input_three,
    input wire logic mf_input_four,
    input wire logic mf_input_five,
    input wire logic step_bit0_in,
    input wire logic step_bit1_in,
    input wire logic step_bit2_in,
    input wire logic key_run,
    input wire logic key_stop,
    input wire logic remote_key_run,
    input wire logic remote_key_stop,
    input wire logic remote_keypad_present,
    input wire logic signed [ANALOG_W-1:0] bipolar_volt_in,
    input wire logic [15:0] analog_freq_in,
    input wire logic fault_active,
    input wire logic motor_stopped,
    output logic run_out,
    output logic reverse_out,
    output logic [15:0] target_freq,
    output logic serial_protocol_sel,
    output logic [7:0] station_number,
    output logic [2:0] baud_sel
);
    logic [31:0] ctrl;
    logic [15:0] freq_cmd;
    logic [31:0] serial_cfg;
    logic [1:0] serial_cmd;
    logic [31:0] mf_func_lo;
    logic [31:0] mf_func_hi;
    logic [1:0] rd_cnt;
    logic [31:0] rd_word;
    logic keypad_run_latch;
    logic term_block;
    logic first_cycle;
    logic fault_seen;
    logic step_from_sel;
    logic [15:0] sel_freq;
    logic [2:0] step_idx_q;
    rcs_state_type state;
    rcs_state_type next_state;

    function automatic logic [31:0] merge_be(input logic [31:0] old_val,
                                             input logic [31:0] new_val,
                                             input logic [3:0] be);
        logic [31:0] res;
        res = old_val;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = new_val[b*8 +: 8];
            end
        end
        return res;
    endfunction : merge_be

    // Bus decode
    wire wr = avs_write;
    wire [31:0] freq_merge = merge_be({16'h0000, freq_cmd}, avs_writedata, avs_byteenable);
    wire rd_start = avs_read && (rd_cnt == 2'h0);
    wire hit_ctrl = (avs_address == REG_CTRL);
    wire hit_freq = (avs_address == REG_FREQ_CMD);
    wire hit_scfg = (avs_address == REG_SERIAL_CFG);
    wire hit_scmd = (avs_address == REG_SERIAL_CMD);
    wire hit_flo = (avs_address == REG_MF_FUNC_LO);
    wire hit_fhi = (avs_address == REG_MF_FUNC_HI);
    wire hit_stat = (avs_address == REG_STATUS);
    wire hit_step = (avs_address >= REG_STEP_FIRST) && (avs_address <= REG_STEP_LAST)
                    && (avs_address[1:0] == 2'b00);
    wire [7:0] step_off = avs_address - REG_STEP_FIRST;
    wire [2:0] bus_step_idx = step_off[4:2] + 3'h1;

    // Writes take effect at once; reads always wait two cycles so step
    // memory reads and register reads have the same latency.
    assign avs_waitrequest = avs_read && (rd_cnt != READ_DONE_CYCLE);

    always_ff @(posedge mclk) begin
        if (reset) begin
            rd_cnt <= 2'h0;
        end else if (avs_read && rd_cnt != READ_DONE_CYCLE) begin
            rd_cnt <= rd_cnt + 2'h1;
        end else begin
            rd_cnt <= 2'h0;
        end
    end

    // Settings registers
    always_ff @(posedge mclk) begin
        if (reset) begin
            ctrl <= CTRL_INIT;
            freq_cmd <= 16'h0000;
            serial_cfg <= SERIAL_CFG_RESET;
            serial_cmd <= 2'h0;
            mf_func_lo <= MF_FUNC_LO_RESET;
            mf_func_hi <= MF_FUNC_HI_RESET;
        end else if (wr) begin
            if (hit_ctrl) begin
                ctrl <= merge_be(ctrl, avs_writedata, avs_byteenable);
            end
            if (hit_freq) begin
                freq_cmd <= freq_merge[15:0];
            end
            if (hit_scfg) begin
                serial_cfg <= merge_be(serial_cfg, avs_writedata, avs_byteenable);
            end
            if (hit_scmd && avs_byteenable[0]) begin
                serial_cmd <= avs_writedata[1:0]; // RQ11
            end
            if (hit_flo) begin
                mf_func_lo <= merge_be(mf_func_lo, avs_writedata, avs_byteenable);
            end
            if (hit_fhi) begin
                mf_func_hi <= merge_be(mf_func_hi, avs_writedata, avs_byteenable);
            end
        end
    end

    wire [1:0] drive_mode = ctrl[CTRL_MODE_LSB +: 2];
    wire keypad_direction_sel = ctrl[CTRL_DIR_BIT];
    wire [3:0] freq_source = ctrl[CTRL_SRC_LSB +: 4];
    wire [1:0] run_inhibit = ctrl[CTRL_INHIBIT_LSB +: 2];
    wire power_on_start_en = ctrl[CTRL_POS_BIT];
    wire fault_restart_en = ctrl[CTRL_FRS_BIT];
    assign serial_protocol_sel = serial_cfg[SER_PROTO_BIT];
    assign station_number = serial_cfg[SER_STATION_LSB +: 8];
    assign baud_sel = serial_cfg[SER_BAUD_LSB +: 3];

    // Terminal decode
    wire forward_run_in;
    wire reverse_run_in;
    wire [2:0] step_idx;
    rcs_term_decode #(
        .TERMS(8)
    ) u_decode (
        .term_in({step_bit2_in, step_bit1_in, step_bit0_in, mf_input_five,
                  mf_input_four, mf_input_three, mf_input_two, mf_input_one}),
        .term_func({mf_func_hi, mf_func_lo}),
        .forward_run_in(forward_run_in),
        .reverse_run_in(reverse_run_in),
        .step_sel(step_idx)
    );

    // Step frequency memory; the bus borrows the read port in the first cycle of step reads
    wire bus_step_rd = rd_start && hit_step;
    wire [2:0] mem_rd_addr = bus_step_rd ? bus_step_idx : step_idx;
    wire [15:0] mem_rd_data;
    rcs_step_mem #(
        .WIDTH(16),
        .DEPTH(8),
        .ADDR_W(3)
    ) u_steps (
        .mclk(mclk),
        .reset(reset),
        .wr_en(wr && hit_step), // RQ2
        .wr_addr(bus_step_idx),
        .wr_data(avs_writedata[15:0]),
        .wr_be(avs_byteenable[1:0]),
        .rd_addr(mem_rd_addr),
        .rd_data(mem_rd_data)
    );

    // Step zero follows the frequency source; bipolar source takes magnitude
    wire src_keypad = (freq_source == SRC_KEYPAD_A) || (freq_source == SRC_KEYPAD_B);
    wire [15:0] step0_freq = src_keypad ? freq_cmd : analog_freq_in; // RQ1 RQ18
    wire [15:0] raw_freq = (step_idx_q == 3'h0) ? step0_freq : mem_rd_data; // RQ1
    wire [15:0] clamp_freq = (raw_freq > FREQ_MAX) ? FREQ_MAX : raw_freq; // RQ2

    always_ff @(posedge mclk) begin
        if (reset) begin
            step_from_sel <= 1'b0;
            step_idx_q <= 3'h0;
            sel_freq <= 16'h0000;
        end else begin
            step_from_sel <= !bus_step_rd;
            step_idx_q <= step_idx;
            // Hold the last good value while the bus owns the read port
            if (step_from_sel && step_idx_q == step_idx) begin
                sel_freq <= clamp_freq;
            end
        end
    end

    // Keypad run latch
    wire eff_run_key = remote_keypad_present ? remote_key_run : key_run; // RQ6
    wire eff_stop_key = remote_keypad_present ? remote_key_stop : key_stop; // RQ6
    wire keypad_mode = (drive_mode == MODE_KEYPAD);

    always_ff @(posedge mclk) begin
        if (reset) begin
            keypad_run_latch <= 1'b0;
        end else if (!keypad_mode || eff_stop_key || fault_active) begin
            keypad_run_latch <= 1'b0; // RQ4
        end else if (eff_run_key && sel_freq != 16'h0000) begin
            keypad_run_latch <= 1'b1; // RQ4
        end
    end

    // Terminal run request per drive mode
    wire term_mode = (drive_mode == MODE_TERM_A) || (drive_mode == MODE_TERM_B);
    wire mode_a_run = forward_run_in ^ reverse_run_in; // RQ8 RQ9
    wire term_run = (drive_mode == MODE_TERM_A) ? mode_a_run : forward_run_in; // RQ10
    wire term_rev = reverse_run_in; // RQ8 RQ10

    // Start qualification after power-up and after a fault clears.
    // A terminal already on at that moment is held off unless the matching
    // enable is set, so a terminal never starts the motor by surprise.
    wire fault_cleared = fault_seen && !fault_active;
    always_ff @(posedge mclk) begin
        if (reset) begin
            first_cycle <= 1'b1;
            fault_seen <= 1'b0;
            term_block <= 1'b1;
        end else begin
            first_cycle <= 1'b0;
            fault_seen <= fault_active;
            if (first_cycle) begin
                term_block <= !(power_on_start_en && term_mode); // RQ15 RQ17 RQ19
            end else if (fault_cleared) begin
                term_block <= !(fault_restart_en && term_mode); // RQ16 RQ17 RQ19
            end else if (!term_run) begin
                term_block <= 1'b0; // RQ19
            end
        end
    end

    // Combine sources
    logic cmd_run;
    logic cmd_rev;
    always_comb begin
        case (drive_mode)
            MODE_KEYPAD: begin
                cmd_run = keypad_run_latch; // RQ4
                cmd_rev = keypad_direction_sel; // RQ5
            end
            MODE_TERM_A, MODE_TERM_B: begin
                cmd_run = term_run && !term_block; // RQ15 RQ16
                cmd_rev = term_rev;
            end
            MODE_SERIAL: begin
                cmd_run = serial_cmd[SCMD_RUN_BIT]; // RQ11
                cmd_rev = serial_cmd[SCMD_REV_BIT]; // RQ11
            end
            default: begin
                cmd_run = 1'b0;
                cmd_rev = 1'b0;
            end
        endcase
    end

    wire volt_negative = bipolar_volt_in[ANALOG_W-1];
    wire want_rev = cmd_rev ^ ((freq_source == SRC_BIPOLAR) && volt_negative); // RQ12
    wire inhibited = ((run_inhibit == INHIBIT_FWD) && !want_rev)
                     || ((run_inhibit == INHIBIT_REV) && want_rev); // RQ14
    wire want_run = cmd_run && !inhibited && !fault_active && !fault_seen; // RQ19

    // Direction sequencer
    always_comb begin
        case (state)
            RCS_IDLE: begin
                if (want_run) begin
                    next_state = want_rev ? RCS_REV : RCS_FWD;
                end else begin
                    next_state = RCS_IDLE;
                end
            end
            RCS_FWD: begin
                if (!want_run) begin
                    next_state = RCS_IDLE;
                end else if (want_rev) begin
                    next_state = RCS_TURN; // RQ13
                end else begin
                    next_state = RCS_FWD;
                end
            end
            RCS_REV: begin
                if (!want_run) begin
                    next_state = RCS_IDLE;
                end else if (!want_rev) begin
                    next_state = RCS_TURN; // RQ13
                end else begin
                    next_state = RCS_REV;
                end
            end
            RCS_TURN: begin
                if (!want_run || motor_stopped) begin
                    next_state = RCS_IDLE; // RQ13
                end else begin
                    next_state = RCS_TURN;
                end
            end
            default: begin
                next_state = RCS_IDLE;
            end
        endcase
    end

    wire next_running = (next_state == RCS_FWD) || (next_state == RCS_REV);
    always_ff @(posedge mclk) begin
        if (reset) begin
            state <= RCS_IDLE;
            run_out <= 1'b0;
            reverse_out <= 1'b0;
            target_freq <= 16'h0000;
        end else begin
            state <= next_state;
            run_out <= (next_state != RCS_IDLE);
            // Direction is frozen through the turn so the ramp brakes correctly
            if (next_running) begin
                reverse_out <= (next_state == RCS_REV);
            end
            target_freq <= next_running ? sel_freq : 16'h0000; // RQ20 RQ13
        end
    end

    // Read data
    logic [31:0] status_word;
    assign status_word = {target_freq, 7'h00, keypad_run_latch, term_block,
                          step_idx, run_out, reverse_out, state};
    always_comb begin
        if (hit_step) begin
            rd_word = {16'h0000, mem_rd_data};
        end else if (hit_ctrl) begin
            rd_word = ctrl;
        end else if (hit_freq) begin
            rd_word = {16'h0000, freq_cmd};
        end else if (hit_scfg) begin
            rd_word = serial_cfg;
        end else if (hit_scmd) begin
            rd_word = {30'h00000000, serial_cmd};
        end else if (hit_flo) begin
            rd_word = mf_func_lo;
        end else if (hit_fhi) begin
            rd_word = mf_func_hi;
        end else if (hit_stat) begin
            rd_word = status_word;
        end else begin
            rd_word = 32'h00000000;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && rd_cnt == READ_LOAD_CYCLE) begin
            avs_readdata <= rd_word;
        end
    end
endmodule : rcs_run_ctrl

/* hdl/rcs_pkg.sv */
package rcs_pkg;
    // Bus map, byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_FREQ_CMD = 8'h04;
    localparam logic [7:0] REG_SERIAL_CFG = 8'h08;
    localparam logic [7:0] REG_SERIAL_CMD = 8'h0C;
    localparam logic [7:0] REG_MF_FUNC_LO = 8'h10;
    localparam logic [7:0] REG_MF_FUNC_HI = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;
    localparam logic [7:0] REG_STEP_FIRST = 8'h20;
    localparam logic [7:0] REG_STEP_LAST = 8'h38;

    // Control fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_DIR_BIT = 2;
    localparam int CTRL_SRC_LSB = 4;
    localparam int CTRL_INHIBIT_LSB = 8;
    localparam int CTRL_POS_BIT = 10;
    localparam int CTRL_FRS_BIT = 11;
    localparam logic [31:0] CTRL_RESET = 32'h00000001;

    // Serial settings and command fields
    localparam int SER_PROTO_BIT = 0;
    localparam int SER_STATION_LSB = 8;
    localparam int SER_BAUD_LSB = 16;
    localparam logic [31:0] SERIAL_CFG_RESET = 32'h00030100;
    localparam int SCMD_RUN_BIT = 0;
    localparam int SCMD_REV_BIT = 1;

    // Terminal function codes, one byte lane per terminal
    localparam logic [31:0] MF_FUNC_LO_RESET = 32'h03020100;
    localparam logic [31:0] MF_FUNC_HI_RESET = 32'h07060504;
    localparam logic [4:0] FUNC_FWD_RUN = 5'h00;
    localparam logic [4:0] FUNC_REV_RUN = 5'h01;
    localparam logic [4:0] FUNC_STEP_BIT0 = 5'h05;

    // Drive modes, frequency sources, inhibit codes
    localparam logic [1:0] MODE_KEYPAD = 2'h0;
    localparam logic [1:0] MODE_TERM_A = 2'h1;
    localparam logic [1:0] MODE_TERM_B = 2'h2;
    localparam logic [1:0] MODE_SERIAL = 2'h3;
    localparam logic [3:0] SRC_KEYPAD_A = 4'h0;
    localparam logic [3:0] SRC_KEYPAD_B = 4'h1;
    localparam logic [3:0] SRC_BIPOLAR = 4'h2;
    localparam logic [1:0] INHIBIT_FWD = 2'h1;
    localparam logic [1:0] INHIBIT_REV = 2'h2;

    // Frequencies in 0.01 Hz
    localparam logic [15:0] FREQ_MAX = 16'h9C40;
    localparam logic [8*16-1:0] STEP_RESET = {16'h05DC, 16'h07D0, 16'h09C4, 16'h0BB8,
                                              16'h0BB8, 16'h07D0, 16'h03E8, 16'h0000};

    // Bus read latency in wait cycles
    localparam logic [1:0] READ_LOAD_CYCLE = 2'h1;
    localparam logic [1:0] READ_DONE_CYCLE = 2'h2;

    typedef enum logic [1:0] {
        RCS_IDLE = 2'b00,
        RCS_FWD = 2'b01,
        RCS_TURN = 2'b11,
        RCS_REV = 2'b10
    } rcs_state_type;
endpackage : rcs_pkg

/* hdl/rcs_step_mem.sv */
`timescale 1ns/100ps
module rcs_step_mem import rcs_pkg::*; #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8,
    parameter int ADDR_W = 3
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [1:0] wr_be,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [0:DEPTH-1];

    always_ff @(posedge mclk) begin
        if (reset) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= STEP_RESET[i*16 +: 16];
            end
            rd_data <= '0;
        end else begin
            if (wr_en && wr_be[0]) begin
                mem[wr_addr][7:0] <= wr_data[7:0];
            end
            if (wr_en && wr_be[1]) begin
                mem[wr_addr][WIDTH-1:8] <= wr_data[WIDTH-1:8];
            end
            rd_data <= mem[rd_addr];
        end
    end
endmodule : rcs_step_mem

/* hdl/rcs_term_decode.sv */
`timescale 1ns/100ps
module rcs_term_decode import rcs_pkg::*; #(
    parameter int TERMS = 8
) (
    input wire logic [TERMS-1:0] term_in,
    input wire logic [TERMS*8-1:0] term_func,
    output logic forward_run_in,
    output logic reverse_run_in,
    output logic [2:0] step_sel
);
    logic [TERMS-1:0] hit_fwd;
    logic [TERMS-1:0] hit_rev;
    logic [TERMS-1:0] hit_s0;
    logic [TERMS-1:0] hit_s1;
    logic [TERMS-1:0] hit_s2;

    genvar g;
    generate
        for (g = 0; g < TERMS; g++) begin : gen_term
            wire [4:0] code = term_func[g*8 +: 5];
            assign hit_fwd[g] = term_in[g] && (code == FUNC_FWD_RUN); // RQ7
            assign hit_rev[g] = term_in[g] && (code == FUNC_REV_RUN); // RQ7
            assign hit_s0[g] = term_in[g] && (code == FUNC_STEP_BIT0); // RQ3
            assign hit_s1[g] = term_in[g] && (code == FUNC_STEP_BIT0 + 5'h01); // RQ3
            assign hit_s2[g] = term_in[g] && (code == FUNC_STEP_BIT0 + 5'h02); // RQ3
        end
    endgenerate

    assign forward_run_in = |hit_fwd;
    assign reverse_run_in = |hit_rev;
    assign step_sel = {|hit_s2, |hit_s1, |hit_s0}; // RQ3
endmodule : rcs_term_decode

/* verification/rcs_run_ctrl_assertions.sv */
`timescale 1ns/100ps
module rcs_run_ctrl_assertions import rcs_pkg::*; (
    input wire logic mclk,
    input wire logic reset,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic fault_active,
    input wire logic motor_stopped,
    input wire logic run_out,
    input wire logic reverse_out,
    input wire logic [15:0] target_freq
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    a_write_no_wait: assert property (avs_write |-> !avs_waitrequest)
        else $error("write was stalled");
    a_read_two_waits: assert property ($rose(avs_read) |->
        avs_waitrequest[*2] ##1 !avs_waitrequest) else $error("read answer mistimed");
    a_idle_no_wait: assert property (!avs_read |-> !avs_waitrequest)
        else $error("wait without read");
    a_stop_no_freq: assert property (!run_out |-> target_freq == 16'h0000)
        else $error("frequency while stopped");
    a_freq_clamp: assert property (target_freq <= FREQ_MAX)
        else $error("frequency above limit");
    a_fault_stops: assert property (fault_active |=> (!run_out)[*2])
        else $error("running during fault");
    a_turn_holds: assert property (run_out && target_freq == 16'h0000 &&
        !motor_stopped && !fault_active |=> run_out && $stable(reverse_out))
        else $error("turn phase left early");
    a_reverse_via_idle: assert property (run_out && $changed(reverse_out) |->
        !$past(run_out)) else $error("direction flipped while running");
endmodule : rcs_run_ctrl_assertions
bind rcs_run_ctrl rcs_run_ctrl_assertions i_chk (.*);

/* verification/rcs_plant_model.sv */
`timescale 1ns/100ps
module rcs_plant_model import rcs_pkg::*; #(
    parameter logic [15:0] RAMP = 16'h0100
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [15:0] target_freq,
    output logic motor_stopped
);
    logic [15:0] speed;
    wire [15:0] next_speed = (speed > target_freq + RAMP) ? speed - RAMP :
        (speed + RAMP < target_freq) ? speed + RAMP : target_freq;
    assign motor_stopped = (speed == 16'h0000);
    always_ff @(posedge mclk) begin
        if (reset) begin
            speed <= 16'h0000;
        end else begin
            speed <= next_speed;
        end
    end
endmodule : rcs_plant_model

/* verification/rcs_run_ctrl_test.sv */
`timescale 1ns/100ps
module rcs_run_ctrl_test import rcs_pkg::*; ;
    localparam logic [15:0] FCMD = 16'h1234;
    localparam logic [15:0] ANLG = 16'h0BB8;
    logic mclk, reset, avs_read, avs_write, avs_waitrequest, run_out, reverse_out;
    logic mf_input_one, mf_input_two, mf_input_three, fault_active, motor_stopped;
    logic step_bit0_in, step_bit1_in, step_bit2_in, remote_keypad_present, serial_protocol_sel;
    logic [3:0] keys;
    logic [2:0] baud_sel;
    logic [7:0] avs_address, station_number;
    logic [15:0] target_freq;
    logic [31:0] avs_writedata, avs_readdata, rd_val;
    logic signed [11:0] bipolar_volt_in;
    int num_errors = 0;
    int cmp_count = 0;
    rcs_run_ctrl #(.CTRL_INIT(32'h00000401)) i_dut (.*, .avs_byteenable(4'hF),
        .mf_input_four(1'b0), .mf_input_five(1'b0), .key_run(keys[0]), .key_stop(keys[1]),
        .remote_key_run(keys[2]), .remote_key_stop(keys[3]), .analog_freq_in(ANLG));
    rcs_plant_model i_plant (.mclk, .reset, .target_freq, .motor_stopped);
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        {avs_address, avs_writedata, avs_write, avs_read} <= {a, d, w, !w};
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        rd_val = avs_readdata;
        {avs_write, avs_read} <= 2'b00;
        @(posedge mclk);
    endtask : bus
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk("readdata", e, rd_val);
    endtask : rdc
    task automatic st(input logic r = 1'b0, input logic v = 1'b0,
                      input logic [15:0] f = 16'h0000);
        int n = 0;
        repeat (2) @(negedge mclk);
        while (n < 400 && !(run_out === r && (!r || reverse_out === v) &&
            target_freq === f)) begin
            @(negedge mclk);
            n++;
        end
        chk("run_out", r, run_out);
        if (r) chk("reverse_out", v, reverse_out);
        chk("target_freq", f, target_freq);
        @(posedge mclk);
    endtask : st
    task automatic tg(input logic f, input logic r);
        @(posedge mclk);
        mf_input_one <= f;
        mf_input_two <= r;
    endtask : tg
    task automatic press(input int b);
        @(posedge mclk);
        keys <= 4'h1 << b;
        @(posedge mclk);
        keys <= 4'h0;
    endtask : press
    task automatic flt(input logic r);
        fault_active <= 1'b1;
        st();
        fault_active <= 1'b0;
        st(r, 1'b0, r ? FCMD : 16'h0000);
    endtask : flt
    task automatic t_power_steps;
        st(1'b1, 1'b0, 16'h03E8);
        bus(1'b1, REG_FREQ_CMD, {16'h0000, FCMD});
        for (int i = 0; i < 8; i++) begin
            {step_bit2_in, step_bit1_in, step_bit0_in} <= 3'(i);
            st(1'b1, 1'b0, (i == 0) ? FCMD : STEP_RESET[i*16+:16]);
        end
        bus(1'b1, REG_STEP_FIRST, 32'h0000FFFF);
        {step_bit2_in, step_bit1_in, step_bit0_in} <= 3'h1;
        st(1'b1, 1'b0, FREQ_MAX);
        {step_bit2_in, step_bit1_in, step_bit0_in} <= 3'h0;
        st(1'b1, 1'b0, FCMD);
    endtask : t_power_steps
    task automatic t_regs;
        rdc(REG_CTRL, 32'h00000401);
        rdc(REG_SERIAL_CFG, SERIAL_CFG_RESET);
        rdc(REG_MF_FUNC_HI, MF_FUNC_HI_RESET);
        rdc(REG_STEP_LAST, 32'h000005DC);
        bus(1'b1, 8'h40, 32'hFFFFFFFF);
        rdc(8'h40, 32'h00000000);
        bus(1'b1, REG_SERIAL_CFG, 32'h0004FA01);
        chk("station_number", 32'hFA, station_number);
        chk("baud_sel", 32'h4, baud_sel);
        chk("serial_protocol_sel", 32'h1, serial_protocol_sel);
    endtask : t_regs
    task automatic t_mode1;
        tg(1'b1, 1'b1);
        st();
        tg(1'b0, 1'b1);
        st(1'b1, 1'b1, FCMD);
        tg(1'b1, 1'b0);
        repeat (2) @(negedge mclk);
        chk("turn_run", 32'h1, run_out);
        chk("turn_freq", 32'h0, target_freq);
        st(1'b1, 1'b0, FCMD);
        tg(1'b0, 1'b0);
        st();
        bus(1'b1, REG_MF_FUNC_LO, 32'h03000102);
        mf_input_three <= 1'b1;
        st(1'b1, 1'b0, FCMD);
        mf_input_three <= 1'b0;
        bus(1'b1, REG_MF_FUNC_LO, MF_FUNC_LO_RESET);
        st();
    endtask : t_mode1
    task automatic t_mode2;
        bus(1'b1, REG_CTRL, 32'h00000002);
        tg(1'b1, 1'b0);
        st(1'b1, 1'b0, FCMD);
        tg(1'b1, 1'b1);
        st(1'b1, 1'b1, FCMD);
        tg(1'b0, 1'b1);
        st();
    endtask : t_mode2
    task automatic t_inhibit;
        bus(1'b1, REG_CTRL, 32'h00000101);
        tg(1'b1, 1'b0);
        st();
        tg(1'b0, 1'b1);
        st(1'b1, 1'b1, FCMD);
        bus(1'b1, REG_CTRL, 32'h00000201);
        st();
        tg(1'b1, 1'b0);
        st(1'b1, 1'b0, FCMD);
        tg(1'b0, 1'b0);
    endtask : t_inhibit
    task automatic t_bipolar;
        bus(1'b1, REG_CTRL, 32'h00000021);
        tg(1'b1, 1'b0);
        st(1'b1, 1'b0, ANLG);
        bipolar_volt_in <= 12'hF00;
        st(1'b1, 1'b1, ANLG);
        tg(1'b0, 1'b1);
        st(1'b1, 1'b0, ANLG);
        tg(1'b0, 1'b0);
        bipolar_volt_in <= 12'h100;
    endtask : t_bipolar
    task automatic t_keypad;
        bus(1'b1, REG_CTRL, 32'h00000004);
        press(0);
        st(1'b1, 1'b1, FCMD);
        press(1);
        st();
        remote_keypad_present <= 1'b1;
        press(0);
        st();
        press(2);
        st(1'b1, 1'b1, FCMD);
        press(3);
        st();
        remote_keypad_present <= 1'b0;
    endtask : t_keypad
    task automatic t_serial;
        bus(1'b1, REG_CTRL, 32'h00000003);
        bus(1'b1, REG_SERIAL_CMD, 32'h00000003);
        st(1'b1, 1'b1, FCMD);
        tg(1'b1, 1'b1);
        st(1'b1, 1'b1, FCMD);
        bus(1'b1, REG_SERIAL_CMD, 32'h00000000);
        st();
        tg(1'b0, 1'b0);
    endtask : t_serial
    task automatic t_fault;
        bus(1'b1, REG_CTRL, 32'h00000801);
        tg(1'b1, 1'b0);
        st(1'b1, 1'b0, FCMD);
        flt(1'b1);
        bus(1'b1, REG_CTRL, 32'h00000001);
        flt(1'b0);
        tg(1'b0, 1'b0);
        tg(1'b1, 1'b0);
        st(1'b1, 1'b0, FCMD);
        tg(1'b0, 1'b0);
        bus(1'b1, REG_CTRL, 32'h00000800);
        press(0);
        st(1'b1, 1'b0, FCMD);
        flt(1'b0);
    endtask : t_fault
    task automatic test_done;
        if (num_errors == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    initial begin
        {avs_read, avs_write, mf_input_two, mf_input_three, fault_active, step_bit1_in} = '0;
        {step_bit2_in, remote_keypad_present, keys, avs_address, avs_writedata} = '0;
        {reset, mf_input_one, step_bit0_in} = 3'h7;
        bipolar_volt_in = 12'h100;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        t_power_steps();
        t_regs();
        t_mode1();
        t_mode2();
        t_inhibit();
        t_bipolar();
        t_keypad();
        t_serial();
        t_fault();
        test_done();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        test_done();
    end
endmodule : rcs_run_ctrl_test
